// ---- logic/vector_map_regs.svh ----
`ifndef VECTOR_MAP_REGS_SVH
`define VECTOR_MAP_REGS_SVH

// vector region and slot numbering
`define VEC_BASE 16'hFFCC
`define VEC_TOP 16'hFFFF
`define VEC_RESET_HI 16'hFFFE
`define SLOT_RESET 5'h19
`define SLOT_NONE 5'h1F
`define NUM_SOURCES 26

// stack and ram map
`define SP_RESET 16'h00FF
`define RAM_LO_BASE 16'h0050
`define RAM_LO_END 16'h044F
`define RAM_HI_BASE 16'h0A00
`define RAM_HI_END 16'h0DFF
`define RAM_HI_OFS 16'h0400
`define RAM_BYTES 2048
`define RAM_IDX_W 11

// bytes moved per stacking operation
`define IRQ_STACK_BYTES 3'h5
`define CALL_STACK_BYTES 3'h2

`endif

// ---- logic/vector_map_pkg.sv ----
package vector_map_pkg;

   typedef enum logic
   {
      VARIANT_A = 1'b0,
      VARIANT_B = 1'b1
   } variant_t;

   typedef enum logic [2:0]
   {
      CMD_NONE = 3'h0,
      CMD_IRQ = 3'h1,
      CMD_CALL = 3'h2,
      CMD_RTS = 3'h3,
      CMD_RTI = 3'h4,
      CMD_LOAD_SP = 3'h5,
      CMD_LOAD_DEFAULT = 3'h6,
      CMD_RESET_VEC = 3'h7
   } cmd_t;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_PUSH = 3'h1,
      ST_PULL_ADDR = 3'h2,
      ST_PULL_DATA = 3'h3,
      ST_FETCH_HI = 3'h4,
      ST_FETCH_LO = 3'h5,
      ST_CAP_HI = 3'h6,
      ST_CAP_LO = 3'h7
   } fsm_t;

   typedef enum logic [4:0]
   {
      SRC_TA_CH0 = 5'h00,
      SRC_TA_CH1 = 5'h01,
      SRC_TA_CH2 = 5'h02,
      SRC_TA_CH3 = 5'h03,
      SRC_TA_CH4 = 5'h04,
      SRC_TA_CH5 = 5'h05,
      SRC_TA_OVF = 5'h06,
      SRC_TB_OVF = 5'h07,
      SRC_TB_CH0 = 5'h08,
      SRC_TB_CH1 = 5'h09,
      SRC_ADC = 5'h0A,
      SRC_KBD = 5'h0B,
      SRC_SCI_TX = 5'h0C,
      SRC_SCI_RX = 5'h0D,
      SRC_SCI_ERR = 5'h0E,
      SRC_CAN_TX = 5'h0F,
      SRC_CAN_RX = 5'h10,
      SRC_CAN_ERR = 5'h11,
      SRC_CAN_WAKE = 5'h12,
      SRC_SPI_TX = 5'h13,
      SRC_SPI_RX = 5'h14,
      SRC_PIT = 5'h15,
      SRC_BYTE_LINK = 5'h16,
      SRC_PLL = 5'h17,
      SRC_EXT_IRQ = 5'h18,
      SRC_SWI = 5'h19
   } src_t;

endpackage

// ---- logic/stack_ram_if.sv ----
`timescale 1ns/10ps
`include "vector_map_regs.svh"

interface stack_ram_if;
   logic en;
   logic we;
   logic [`RAM_IDX_W-1:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport ctrl (output en, output we, output idx, output wdata,
      input rdata);
   modport mem (input en, input we, input idx, input wdata,
      output rdata);
endinterface

// ---- logic/stack_ram.sv ----
`timescale 1ns/10ps
`include "vector_map_regs.svh"

module stack_ram
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // access port
   stack_ram_if.mem port
);

   logic [7:0] mem_reg [0:`RAM_BYTES-1];

   // array itself carries no reset
   always_ff @(posedge sys_clk_i)
   begin
      if (port.en && port.we)
      begin
         mem_reg[port.idx] <= port.wdata;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         port.rdata <= 8'h00;
      end
      else if (port.en)
      begin
         port.rdata <= mem_reg[port.idx];
      end
   end

endmodule // stack_ram

// ---- logic/vector_map_and_stack.sv ----
`timescale 1ns/10ps
`include "vector_map_regs.svh"

// Function
// - vector fetches read only FFCC to FFFF
// - higher vector address means higher priority
// - high byte even address, low byte odd
// - variant parameter selects slot assignment
// - variant A low slots timer, converter, serial
// - variant A CAN slots FFDA to FFE0
// - variant A SPI from FFE2, then timer_b from FFE6
// - variant A timer_a overflow FFEC, periodic FFF6
// - variant B reserved, periodic from FFDA
// - variant B SPI FFE6, timer_a from FFEA
// - loadable sixteen bit stack pointer
// - stack pointer resets to 00FF
// - interrupt entry pushes five context bytes
// - high index byte never stacked
// - subroutine call pushes two bytes
// - decrement on push, increment on pull
// - 2048 byte RAM, 176 in page zero
module vector_map_and_stack
#(
   parameter vector_map_pkg::variant_t VARIANT = vector_map_pkg::VARIANT_A
)
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // peripheral requests, one bit per source
   input wire logic [`NUM_SOURCES-1:0] src_req_i,
   // core commands
   input wire logic cmd_valid_i,
   input wire vector_map_pkg::cmd_t cmd_i,
   input wire logic [7:0] ctx_ccr_i,
   input wire logic [7:0] ctx_a_i,
   input wire logic [7:0] ctx_x_i,
   input wire logic [15:0] ctx_pc_i,
   input wire logic [15:0] sp_value_i,
   // command results
   output logic busy_o,
   output logic done_o,
   output logic [4:0] slot_o,
   output logic [15:0] handler_addr_o,
   output logic [39:0] pulled_o,
   output logic [15:0] sp_o,
   output logic sp_fault_o,
   // vector memory read port
   output logic vec_rd_o,
   output logic [15:0] vec_addr_o,
   input wire logic [7:0] vec_data_i,
   // core ram port
   input wire logic ram_req_i,
   input wire logic ram_we_i,
   input wire logic ram_direct_i,
   input wire logic [15:0] ram_addr_i,
   input wire logic [7:0] ram_wdata_i,
   output logic ram_ack_o,
   output logic ram_hit_o,
   output logic [7:0] ram_rdata_o
);
   import vector_map_pkg::*;

   typedef struct packed {
      fsm_t st;
      logic [15:0] sp;
      logic [2:0] cnt;
      logic [4:0] slot;
      logic [39:0] ctx;
      logic [39:0] pulled;
      logic [15:0] handler;
      logic [15:0] vec_addr;
      logic vec_rd;
      logic busy;
      logic done;
      logic fault;
      logic ack;
      logic hit;
   } state_t;

   state_t r;
   state_t nx;
   stack_ram_if ram ();
   logic [4:0] src_slot [0:`NUM_SOURCES-1];
   logic [31:0] slot_req;
   logic [4:0] pend;
   logic [11:0] map;
   logic [15:0] nsp;

   // slot number of each source per variant
   function automatic logic [4:0] slot_of(input variant_t v,
      input src_t s);
      logic a;
      a = (v == VARIANT_A);
      case (s)
         SRC_TA_CH5: slot_of = a ? 5'h00 : 5'h10;
         SRC_TA_CH4: slot_of = a ? 5'h01 : 5'h11;
         SRC_ADC: slot_of = a ? 5'h02 : 5'h09;
         SRC_KBD: slot_of = 5'h03;
         SRC_SCI_TX: slot_of = a ? 5'h04 : 5'h0A;
         SRC_SCI_RX: slot_of = a ? 5'h05 : 5'h0B;
         SRC_SCI_ERR: slot_of = a ? 5'h06 : 5'h0C;
         SRC_CAN_TX: slot_of = a ? 5'h07 : `SLOT_NONE;
         SRC_CAN_RX: slot_of = a ? 5'h08 : `SLOT_NONE;
         SRC_CAN_ERR: slot_of = a ? 5'h09 : `SLOT_NONE;
         SRC_CAN_WAKE: slot_of = a ? 5'h0A : `SLOT_NONE;
         SRC_SPI_TX: slot_of = a ? 5'h0B : 5'h0D;
         SRC_SPI_RX: slot_of = a ? 5'h0C : 5'h0E;
         SRC_TB_OVF: slot_of = a ? 5'h0D : `SLOT_NONE;
         SRC_TB_CH1: slot_of = a ? 5'h0E : `SLOT_NONE;
         SRC_TB_CH0: slot_of = a ? 5'h0F : `SLOT_NONE;
         SRC_TA_OVF: slot_of = a ? 5'h10 : 5'h0F;
         SRC_TA_CH3: slot_of = a ? 5'h11 : 5'h12;
         SRC_TA_CH2: slot_of = a ? 5'h12 : 5'h13;
         SRC_TA_CH1: slot_of = a ? 5'h13 : 5'h14;
         SRC_TA_CH0: slot_of = a ? 5'h14 : 5'h15;
         SRC_PIT: slot_of = a ? 5'h15 : 5'h07;
         SRC_BYTE_LINK: slot_of = a ? `SLOT_NONE : 5'h08;
         SRC_PLL: slot_of = 5'h16;
         SRC_EXT_IRQ: slot_of = 5'h17;
         SRC_SWI: slot_of = 5'h18;
         default: slot_of = `SLOT_NONE;
      endcase
   endfunction

   // highest requesting slot below reset, else none
   function automatic logic [4:0] top_slot(input logic [31:0] req);
      top_slot = `SLOT_NONE;
      for (int i = 0; i < 25; i++)
      begin
         if (req[i])
         begin
            top_slot = i[4:0];
         end
      end
   endfunction

   // {hit, index} of a ram address
   function automatic logic [11:0] ram_index(input logic [15:0] a);
      logic [15:0] d;
      d = 16'h0000;
      ram_index = 12'h000;
      if (a >= `RAM_LO_BASE && a <= `RAM_LO_END)
      begin
         d = a - `RAM_LO_BASE;
         ram_index = {1'b1, d[10:0]};
      end
      else if (a >= `RAM_HI_BASE && a <= `RAM_HI_END)
      begin
         d = a - `RAM_HI_BASE + `RAM_HI_OFS;
         ram_index = {1'b1, d[10:0]};
      end
   endfunction

   generate
      for (genvar g = 0; g < `NUM_SOURCES; g++)
      begin : g_src
         assign src_slot[g] = slot_of(VARIANT, src_t'(g));
      end
   endgenerate

   always_comb
   begin
      slot_req = 32'h00000000;
      for (int i = 0; i < `NUM_SOURCES; i++)
      begin
         if (src_req_i[i] && src_slot[i] != `SLOT_NONE)
         begin
            slot_req[src_slot[i]] = 1'b1;
         end
      end
   end

   assign pend = top_slot(slot_req);

   always_comb
   begin
      nx = r;
      nx.done = 1'b0;
      nx.ack = 1'b0;
      nx.vec_rd = 1'b0;
      ram.en = 1'b0;
      ram.we = 1'b0;
      ram.idx = '0;
      ram.wdata = 8'h00;
      map = 12'h000;
      nsp = r.sp + 16'h0001;
      case (r.st)
         ST_IDLE:
         begin
            if (cmd_valid_i)
            begin
               case (cmd_i)
                  CMD_IRQ:
                  begin
                     if (pend != `SLOT_NONE)
                     begin
                        nx.slot = pend;
                        // h byte is left out of the frame
                        nx.ctx = {ctx_ccr_i, ctx_a_i, ctx_x_i,
                           ctx_pc_i};
                        nx.cnt = `IRQ_STACK_BYTES;
                        nx.st = ST_PUSH;
                        nx.busy = 1'b1;
                     end
                  end
                  CMD_CALL:
                  begin
                     nx.slot = `SLOT_NONE;
                     nx.ctx = {24'h000000, ctx_pc_i};
                     nx.cnt = `CALL_STACK_BYTES;
                     nx.st = ST_PUSH;
                     nx.busy = 1'b1;
                  end
                  CMD_RTS:
                  begin
                     nx.pulled = 40'h0000000000;
                     nx.cnt = `CALL_STACK_BYTES;
                     nx.st = ST_PULL_ADDR;
                     nx.busy = 1'b1;
                  end
                  CMD_RTI:
                  begin
                     nx.pulled = 40'h0000000000;
                     nx.cnt = `IRQ_STACK_BYTES;
                     nx.st = ST_PULL_ADDR;
                     nx.busy = 1'b1;
                  end
                  CMD_LOAD_SP:
                  begin
                     nx.sp = sp_value_i;
                     nx.fault = 1'b0;
                     nx.done = 1'b1;
                  end
                  CMD_LOAD_DEFAULT:
                  begin
                     nx.sp = `SP_RESET;
                     nx.fault = 1'b0;
                     nx.done = 1'b1;
                  end
                  CMD_RESET_VEC:
                  begin
                     nx.slot = `SLOT_RESET;
                     nx.st = ST_FETCH_HI;
                     nx.busy = 1'b1;
                  end
                  default:
                  begin
                     nx.st = ST_IDLE;
                  end
               endcase
            end
            else if (ram_req_i)
            begin
               // direct mode reaches page zero only
               map = ram_index(ram_direct_i ?
                  {8'h00, ram_addr_i[7:0]} : ram_addr_i);
               ram.en = map[11];
               ram.we = ram_we_i;
               ram.idx = map[10:0];
               ram.wdata = ram_wdata_i;
               nx.ack = 1'b1;
               nx.hit = map[11];
            end
         end
         ST_PUSH:
         begin
            map = ram_index(r.sp);
            ram.en = map[11];
            ram.we = 1'b1;
            ram.idx = map[10:0];
            ram.wdata = r.ctx[7:0];
            nx.ctx = {8'h00, r.ctx[39:8]};
            nx.sp = r.sp - 16'h0001;
            nx.cnt = r.cnt - 3'h1;
            if (!map[11])
            begin
               nx.fault = 1'b1;
            end
            if (r.cnt == 3'h1)
            begin
               if (r.slot == `SLOT_NONE)
               begin
                  nx.st = ST_IDLE;
                  nx.busy = 1'b0;
                  nx.done = 1'b1;
               end
               else
               begin
                  nx.st = ST_FETCH_HI;
               end
            end
         end
         ST_PULL_ADDR:
         begin
            map = ram_index(nsp);
            ram.en = map[11];
            ram.idx = map[10:0];
            nx.sp = nsp;
            nx.st = ST_PULL_DATA;
            if (!map[11])
            begin
               nx.fault = 1'b1;
            end
         end
         ST_PULL_DATA:
         begin
            nx.pulled = {r.pulled[31:0], ram.rdata};
            nx.cnt = r.cnt - 3'h1;
            if (r.cnt == 3'h1)
            begin
               nx.st = ST_IDLE;
               nx.busy = 1'b0;
               nx.done = 1'b1;
            end
            else
            begin
               nx.st = ST_PULL_ADDR;
            end
         end
         ST_FETCH_HI:
         begin
            nx.vec_rd = 1'b1;
            nx.vec_addr = `VEC_BASE + {10'h000, r.slot, 1'b0};
            nx.st = ST_FETCH_LO;
         end
         ST_FETCH_LO:
         begin
            nx.vec_rd = 1'b1;
            nx.vec_addr = r.vec_addr | 16'h0001;
            nx.st = ST_CAP_HI;
         end
         ST_CAP_HI:
         begin
            nx.handler[15:8] = vec_data_i;
            nx.st = ST_CAP_LO;
         end
         ST_CAP_LO:
         begin
            nx.handler[7:0] = vec_data_i;
            nx.st = ST_IDLE;
            nx.busy = 1'b0;
            nx.done = 1'b1;
         end
         default:
         begin
            nx.st = ST_IDLE;
         end
      endcase
   end

   // reset starts with the reset vector fetch
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         r <= '0;
         r.st <= ST_FETCH_HI;
         r.slot <= `SLOT_RESET;
         r.busy <= 1'b1;
         r.sp <= `SP_RESET;
      end
      else
      begin
         r <= nx;
      end
   end

   stack_ram u_ram
   (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .port(ram.mem)
   );

   assign busy_o = r.busy;
   assign done_o = r.done;
   assign slot_o = r.slot;
   assign handler_addr_o = r.handler;
   assign pulled_o = r.pulled;
   assign sp_o = r.sp;
   assign sp_fault_o = r.fault;
   assign vec_rd_o = r.vec_rd;
   assign vec_addr_o = r.vec_addr;
   assign ram_ack_o = r.ack;
   assign ram_hit_o = r.hit;
   assign ram_rdata_o = ram.rdata;

   // checks
   logic first_cyc;
   logic irq_go;

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         first_cyc <= 1'b1;
      end
      else
      begin
         first_cyc <= 1'b0;
      end
   end

   assign irq_go = r.st == ST_IDLE && cmd_valid_i && cmd_i == CMD_IRQ &&
      pend != `SLOT_NONE;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   property p_vec_region;
      vec_rd_o |-> vec_addr_o >= `VEC_BASE;
   endproperty
   a_vec_region: assert property (p_vec_region)
      else $error("vector read outside vector region");

   property p_hi_then_lo;
      vec_rd_o && !vec_addr_o[0] |=>
         vec_rd_o && vec_addr_o == $past(vec_addr_o) + 16'h0001;
   endproperty
   a_hi_then_lo: assert property (p_hi_then_lo)
      else $error("low vector byte not fetched after high byte");

   property p_slot_addr;
      vec_rd_o && !vec_addr_o[0] |->
         vec_addr_o == `VEC_BASE + {10'h000, slot_o, 1'b0};
   endproperty
   a_slot_addr: assert property (p_slot_addr)
      else $error("vector address does not match slot");

   property p_priority;
      irq_go |=> slot_o == $past(top_slot(slot_req));
   endproperty
   a_priority: assert property (p_priority)
      else $error("interrupt slot is not the highest pending");

   property p_sp_init;
      first_cyc |-> sp_o == `SP_RESET;
   endproperty
   a_sp_init: assert property (p_sp_init)
      else $error("stack pointer not at reset value");

   // sampled reset keeps the release edge itself out
   property p_reset_fetch;
      first_cyc && arst_n_i |=> vec_rd_o && vec_addr_o == `VEC_RESET_HI;
   endproperty
   a_reset_fetch: assert property (p_reset_fetch)
      else $error("reset vector not fetched first");

   property p_irq_push5;
      irq_go |-> ##6 sp_o == $past(sp_o, 6) - 16'h0005;
   endproperty
   a_irq_push5: assert property (p_irq_push5)
      else $error("interrupt entry did not stack five bytes");

   property p_call_push2;
      r.st == ST_IDLE && cmd_valid_i && cmd_i == CMD_CALL |->
         ##3 sp_o == $past(sp_o, 3) - 16'h0002;
   endproperty
   a_call_push2: assert property (p_call_push2)
      else $error("call did not stack two bytes");

   property p_rti_pull5;
      r.st == ST_IDLE && cmd_valid_i && cmd_i == CMD_RTI |->
         ##11 sp_o == $past(sp_o, 11) + 16'h0005 && done_o;
   endproperty
   a_rti_pull5: assert property (p_rti_pull5)
      else $error("return from interrupt did not pull five bytes");

   property p_load_sp;
      r.st == ST_IDLE && cmd_valid_i && cmd_i == CMD_LOAD_SP |=>
         sp_o == $past(sp_value_i) && done_o;
   endproperty
   a_load_sp: assert property (p_load_sp)
      else $error("stack pointer load failed");

   c_irq_entry: cover property (irq_go ##6 r.st == ST_FETCH_HI);
   c_rts: cover property (r.st == ST_PULL_DATA && r.cnt == 3'h1);
   c_ram_hit: cover property (ram_ack_o && ram_hit_o);

endmodule // vector_map_and_stack

// ---- tb/vector_rom_model.sv ----
`timescale 1ns/10ps

module vector_rom_model
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // read port from the block
   input wire logic vec_rd_i,
   input wire logic [15:0] vec_addr_i,
   output logic [7:0] vec_data_o
);
   // byte follows the strobe by one cycle, then inverts on every cycle without a strobe
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         vec_data_o <= 8'h00;
      else if (vec_rd_i)
         vec_data_o <= vec_addr_i[7:0] ^ 8'h3C;
      else
         vec_data_o <= ~vec_data_o;
   end
endmodule // vector_rom_model

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`include "vector_map_regs.svh"

module testbench;
   import vector_map_pkg::*;

   localparam logic [4:0] map_a [26] = '{5'h14, 5'h13, 5'h12, 5'h11, 5'h01,
      5'h00, 5'h10, 5'h0D, 5'h0F, 5'h0E, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
      5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h15, 5'h1F, 5'h16, 5'h17,
      5'h18};
   localparam logic [4:0] map_b [26] = '{5'h15, 5'h14, 5'h13, 5'h12, 5'h11,
      5'h10, 5'h0F, 5'h1F, 5'h1F, 5'h1F, 5'h09, 5'h03, 5'h0A, 5'h0B, 5'h0C,
      5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h0D, 5'h0E, 5'h07, 5'h08, 5'h16, 5'h17,
      5'h18};
   localparam logic [15:0] ram_ok [4] = '{16'h0050, 16'h044F, 16'h0A00,
      16'h0DFF};
   localparam logic [15:0] ram_bad [4] = '{16'h004F, 16'h0450, 16'h09FF,
      16'h0E00};

   logic sys_clk_i, arst_n_i, cmd_valid_i, ram_req_i, ram_we_i, ram_direct_i;
   logic [25:0] src_req_i;
   cmd_t cmd_i;
   logic [7:0] ctx_ccr_i, ctx_a_i, ctx_x_i, ram_wdata_i, vdat_a, vdat_b, rdat;
   logic [15:0] ctx_pc_i, sp_value_i, ram_addr_i;
   logic busy_a, done_a, busy_b, done_b, fault, vrd_a, vrd_b, ack, hit;
   logic [4:0] slot_a, slot_b, cs_a, cs_b;
   logic [15:0] hand_a, hand_b, sp_a, vad_a, vad_b, ch_a, ch_b, csp_a;
   logic [39:0] pulled, cpull;
   logic seen_a, seen_b, cfault, hit_c;
   logic [7:0] rd_c;
   integer err_total, total_checks;

   vector_map_and_stack #(.VARIANT(VARIANT_A)) dut
   (
      .sys_clk_i, .arst_n_i, .src_req_i, .cmd_valid_i, .cmd_i,
      .ctx_ccr_i, .ctx_a_i, .ctx_x_i, .ctx_pc_i, .sp_value_i,
      .busy_o(busy_a), .done_o(done_a), .slot_o(slot_a),
      .handler_addr_o(hand_a), .pulled_o(pulled), .sp_o(sp_a),
      .sp_fault_o(fault), .vec_rd_o(vrd_a), .vec_addr_o(vad_a),
      .vec_data_i(vdat_a), .ram_req_i, .ram_we_i, .ram_direct_i,
      .ram_addr_i, .ram_wdata_i, .ram_ack_o(ack), .ram_hit_o(hit),
      .ram_rdata_o(rdat)
   );
   vector_map_and_stack #(.VARIANT(VARIANT_B)) dut_b
   (
      .sys_clk_i, .arst_n_i, .src_req_i, .cmd_valid_i, .cmd_i,
      .ctx_ccr_i, .ctx_a_i, .ctx_x_i, .ctx_pc_i, .sp_value_i,
      .busy_o(busy_b), .done_o(done_b), .slot_o(slot_b),
      .handler_addr_o(hand_b), .pulled_o(), .sp_o(), .sp_fault_o(),
      .vec_rd_o(vrd_b), .vec_addr_o(vad_b), .vec_data_i(vdat_b),
      .ram_req_i, .ram_we_i, .ram_direct_i, .ram_addr_i, .ram_wdata_i,
      .ram_ack_o(), .ram_hit_o(), .ram_rdata_o()
   );
   vector_rom_model rom_a (.sys_clk_i, .arst_n_i, .vec_rd_i(vrd_a),
      .vec_addr_i(vad_a), .vec_data_o(vdat_a));
   vector_rom_model rom_b (.sys_clk_i, .arst_n_i, .vec_rd_i(vrd_b),
      .vec_addr_i(vad_b), .vec_data_o(vdat_b));

   task automatic chk(input string what, input logic [39:0] exp,
      input logic [39:0] got);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   function automatic logic [15:0] exp_hand(input logic [4:0] s);
      logic [15:0] a;
      a = 16'hFFCC + {10'h000, s, 1'b0};
      return {a[7:0] ^ 8'h3C, (a[7:0] + 8'h01) ^ 8'h3C};
   endfunction

   function automatic logic [4:0] winner(input logic [25:0] m, input bit vb);
      logic [4:0] w, s;
      w = 5'h1F;
      for (int k = 0; k < 26; k++)
      begin
         s = vb ? map_b[k] : map_a[k];
         if (m[k] && s != 5'h1F && (w == 5'h1F || s > w))
            w = s;
      end
      return w;
   endfunction

   // catch done of both variants within a bounded window
   task automatic wait_done();
      seen_a = 1'b0;
      seen_b = 1'b0;
      for (int i = 0; i < 16 && !(seen_a && seen_b); i++)
      begin
         @(posedge sys_clk_i);
         if (done_a === 1'b1 && !seen_a)
         begin
            seen_a = 1'b1;
            cs_a = slot_a;
            ch_a = hand_a;
            csp_a = sp_a;
            cpull = pulled;
            cfault = fault;
         end
         if (done_b === 1'b1 && !seen_b)
         begin
            seen_b = 1'b1;
            cs_b = slot_b;
            ch_b = hand_b;
         end
      end
   endtask

   task automatic do_cmd(input cmd_t c);
      integer i;
      for (i = 0; i < 20 && (busy_a !== 1'b0 || busy_b !== 1'b0); i++)
         @(posedge sys_clk_i);
      if (i == 20)
      begin
         err_total++;
         results();
      end
      cmd_i <= c;
      cmd_valid_i <= 1'b1;
      @(posedge sys_clk_i);
      cmd_valid_i <= 1'b0;
      wait_done();
   endtask

   task automatic ram_op(input logic we, input logic dir,
      input logic [15:0] a, input logic [7:0] d);
      integer i;
      ram_req_i <= 1'b1;
      ram_we_i <= we;
      ram_direct_i <= dir;
      ram_addr_i <= a;
      ram_wdata_i <= d;
      for (i = 0; i < 8; i++)
      begin
         @(posedge sys_clk_i);
         if (ack === 1'b1)
            break;
      end
      if (i == 8)
      begin
         err_total++;
         results();
      end
      hit_c = hit;
      rd_c = rdat;
      ram_req_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask

   task automatic t_reset();
      arst_n_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      wait_done();
      chk("reset done", 2'b11, {seen_a, seen_b});
      chk("reset sp", 16'h00FF, csp_a);
      chk("reset slot", 5'h19, cs_a);
      chk("reset vector a", exp_hand(5'h19), ch_a);
      chk("reset vector b", exp_hand(5'h19), ch_b);
      $display("test reset done");
   endtask

   task automatic t_ram();
      for (int k = 0; k < 4; k++)
      begin
         ram_op(1'b1, 1'b0, ram_ok[k], 8'h11 * (k + 1));
         chk("ram hit", 1'b1, hit_c);
         ram_op(1'b1, 1'b0, ram_bad[k], 8'hEE);
         chk("ram miss", 1'b0, hit_c);
      end
      for (int k = 0; k < 4; k++)
      begin
         ram_op(1'b0, 1'b0, ram_ok[k], 8'h00);
         chk("ram data", 8'h11 * (k + 1), rd_c);
      end
      ram_op(1'b1, 1'b1, 16'h12FF, 8'h66);
      ram_op(1'b0, 1'b0, 16'h00FF, 8'h00);
      chk("direct data", 8'h66, rd_c);
      ram_op(1'b0, 1'b1, 16'h56FF, 8'h00);
      chk("direct read", 8'h66, rd_c);
      ram_op(1'b1, 1'b1, 16'h344F, 8'h77);
      chk("direct miss", 1'b0, hit_c);
      $display("test ram done");
   endtask

   task automatic t_irq(input logic [25:0] m);
      logic [4:0] wa, wb;
      wa = winner(m, 1'b0);
      wb = winner(m, 1'b1);
      src_req_i <= m;
      do_cmd(CMD_LOAD_DEFAULT);
      do_cmd(CMD_IRQ);
      chk("irq taken a", wa != 5'h1F, seen_a);
      chk("irq taken b", wb != 5'h1F, seen_b);
      if (seen_a)
      begin
         chk("slot a", wa, cs_a);
         chk("vector a", exp_hand(wa), ch_a);
      end
      if (seen_b)
      begin
         chk("slot b", wb, cs_b);
         chk("vector b", exp_hand(wb), ch_b);
      end
   endtask

   task automatic t_stack_irq();
      logic [47:0] e;
      e = 48'h3412B3A2C15A;
      ctx_ccr_i <= 8'hC1;
      ctx_a_i <= 8'hA2;
      ctx_x_i <= 8'hB3;
      ctx_pc_i <= 16'h1234;
      sp_value_i <= 16'h0200;
      src_req_i <= 26'h1 << 24;
      do_cmd(CMD_LOAD_SP);
      chk("load sp", 16'h0200, csp_a);
      ram_op(1'b1, 1'b0, 16'h01FB, 8'h5A);
      do_cmd(CMD_IRQ);
      chk("irq sp", 16'h01FB, csp_a);
      for (int k = 0; k < 6; k++)
      begin
         ram_op(1'b0, 1'b0, 16'h0200 - k, 8'h00);
         chk("stacked byte", e[47 - 8 * k -: 8], rd_c);
      end
      do_cmd(CMD_RTI);
      chk("rti bytes", 40'hC1A2B31234, cpull);
      chk("rti sp", 16'h0200, csp_a);
      $display("test interrupt stacking done");
   endtask

   task automatic t_stack_call();
      ctx_pc_i <= 16'hBEEF;
      sp_value_i <= 16'h0040;
      do_cmd(CMD_LOAD_SP);
      do_cmd(CMD_CALL);
      chk("fault set", 1'b1, cfault);
      do_cmd(CMD_LOAD_DEFAULT);
      @(posedge sys_clk_i);
      chk("fault clear", 1'b0, fault);
      chk("default sp", 16'h00FF, sp_a);
      sp_value_i <= 16'h0A10;
      do_cmd(CMD_LOAD_SP);
      do_cmd(CMD_CALL);
      chk("call sp", 16'h0A0E, csp_a);
      ram_op(1'b0, 1'b0, 16'h0A10, 8'h00);
      chk("return low", 8'hEF, rd_c);
      ram_op(1'b0, 1'b0, 16'h0A0F, 8'h00);
      chk("return high", 8'hBE, rd_c);
      do_cmd(CMD_RTS);
      chk("rts bytes", 16'hBEEF, cpull[15:0]);
      chk("rts sp", 16'h0A10, csp_a);
      $display("test subroutine stacking done");
   endtask

   task automatic t_resvec();
      do_cmd(CMD_RESET_VEC);
      chk("resvec slot", 5'h19, cs_a);
      chk("resvec a", exp_hand(5'h19), ch_a);
      chk("resvec b", exp_hand(5'h19), ch_b);
      $display("test reset vector command done");
   endtask

   // every fetch must stay inside the vector region
   always @(posedge sys_clk_i)
   begin
      if (vrd_a === 1'b1)
         chk("fetch addr a", 1'b1, vad_a >= 16'hFFCC);
      if (vrd_b === 1'b1)
         chk("fetch addr b", 1'b1, vad_b >= 16'hFFCC);
   end

   initial
   begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   initial
   begin
      err_total = 0;
      total_checks = 0;
      arst_n_i = 1'b0;
      src_req_i = '0;
      cmd_valid_i = 1'b0;
      cmd_i = CMD_NONE;
      ctx_ccr_i = 8'h00;
      ctx_a_i = 8'h00;
      ctx_x_i = 8'h00;
      ctx_pc_i = 16'h0000;
      sp_value_i = 16'h0000;
      ram_req_i = 1'b0;
      ram_we_i = 1'b0;
      ram_direct_i = 1'b0;
      ram_addr_i = 16'h0000;
      ram_wdata_i = 8'h00;
      t_reset();
      t_ram();
      for (int k = 0; k < 26; k++)
         t_irq(26'h1 << k);
      t_irq('1);
      t_irq(26'h0000C00);
      t_irq(26'h0000000);
      $display("test vector map done");
      t_stack_irq();
      t_stack_call();
      t_reset();
      t_resvec();
      results();
   end
endmodule // testbench
